// ==== logic/sync_serial_pkg.sv ====
// shared constants of the serial frame engine
package sync_serial_pkg;
    // frame format field encodings
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_SYNC_SERIAL = 2'h1;
    localparam logic [1:0] FMT_CONTROL_WORD = 2'h2;
    localparam logic [1:0] FMT_RESERVED = 2'h3;
    // control word length in bits
    localparam logic [4:0] CONTROL_BITS = 5'h08;
    // data size field: bits minus one, legal 3..15
    localparam logic [3:0] DATA_SIZE_MIN = 4'h3;
    // second control register values
    localparam logic [31:0] CR1_MASTER = 32'h0000_0000;
    localparam logic [31:0] CR1_SLAVE_OUT = 32'h0000_0004;
    localparam logic [31:0] CR1_SLAVE_NO_OUT = 32'h0000_000c;
    // bit positions in the second control register
    localparam int CR1_ENABLE_POS = 1;
    localparam int CR1_SLAVE_POS = 2;
    localparam int CR1_OUT_OFF_POS = 3;
endpackage

// ==== logic/sync_serial_divider.sv ====
// prescaler producing half-period enable pulses
`timescale 1ns/100ps
`default_nettype none
module sync_serial_divider (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_run,
    input wire logic [7:0] i_prescale_divisor,
    input wire logic [7:0] i_clock_rate_factor,
    // half-period tick
    output logic o_half_tick
);
    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;
    logic [15:0] half_len;

    always_comb begin
        // half period = divisor*(1+factor)/2 cycles, divisor even
        half_len = 16'({8'h00, i_prescale_divisor[7:1]}
            * ({8'h00, i_clock_rate_factor} + 16'h0001));
        next_state = state;
        next_state.tick = 1'b0;
        if (!i_run) begin
            next_state.count = 16'h0000;
        end else if (state.count + 16'h0001 >= half_len) begin
            next_state.count = 16'h0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_half_tick = state.tick;

    a_tick_stops_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_run |=> !o_half_tick)
        else $error("tick while divider stopped");
endmodule
`default_nettype wire

// ==== logic/sync_serial_sync.sv ====
// two-flop synchroniser for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync_serial_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.first = i_async;
        next_state.second = state.first;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // pins idle high, so no false edge after reset
            state <= '1;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.second;
endmodule
`default_nettype wire

// ==== logic/sync_serial_frame_engine.sv ====
// frame sequencer: spi mode 1/1 and half-duplex control-word format
//
// Overview of operation
// - spi idle: clock high, select high, out low
// - drive clock pad only as master
// - master starts: select low, output pad on
// - data half period after select, clock falls
// - sample on rising, change on falling
// - single word: select high one period later
// - back-to-back: select stays low until end
// - control word eight bits out, no input
// - control-word idle: clock low, select high
// - select fall loads fifo word, msb first
// - select low all frame, input ignored
// - device latches response on rising edge
// - select rise one period later pushes word
// - continuous: next control follows lsb
// - slave samples first rising after select
// - format field: 0 spi, 2 control word
`timescale 1ns/100ps
`default_nettype none
module sync_serial_frame_engine (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // configuration
    input wire logic i_port_enable_bit,
    input wire logic i_slave_mode,
    input wire logic i_slave_out_disable,
    input wire logic [1:0] i_frame_format_field,
    input wire logic [3:0] i_data_size_field,
    input wire logic i_clock_polarity_bit,
    input wire logic i_clock_phase_bit,
    input wire logic [7:0] i_prescale_divisor,
    input wire logic [7:0] i_clock_rate_factor,
    // transmit fifo side
    input wire logic i_tx_valid,
    input wire logic [15:0] i_tx_data,
    output logic o_tx_pop,
    // receive fifo side
    output logic o_rx_push,
    output logic [15:0] o_rx_data,
    // status
    output logic o_busy,
    // serial pins
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_pin_oe,
    input wire logic i_frame_select_pin,
    output logic o_frame_select_pin,
    output logic o_frame_select_pin_oe,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    input wire logic i_serial_in_pin
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_FIRST = 3'b010,
        ST_SECOND = 3'b011,
        ST_TAIL = 3'b100
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic sclk;
        logic fss;
        logic sout;
        logic sout_oe;
        logic sclk_oe;
        logic pop;
        logic push;
        logic [15:0] shift_out;
        logic [15:0] shift_in;
        logic [15:0] rx_data;
        logic [4:0] bits_left;
        logic in_response;
        logic wait_bit;
        logic tail_half;
        logic prev_sclk;
        logic prev_fss;
        logic busy;
    } eng_state_t;

    eng_state_t state;
    eng_state_t next_state;
    logic half_tick;
    logic [2:0] pins_sync;
    logic ext_clk;
    logic ext_fss;
    logic ext_in;
    logic cw_mode;
    logic spi_ok;
    logic [4:0] word_bits;
    logic ext_rise;

    // ==========================================================
    // pin synchronisers and prescaler
    sync_serial_sync #(.WIDTH(3)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_serial_clock_pin, i_frame_select_pin,
            i_serial_in_pin}),
        .o_sync(pins_sync)
    );
    assign {ext_clk, ext_fss, ext_in} = pins_sync;

    sync_serial_divider u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        // started with the select fall, so the first half is exact
        .i_run(next_state.phase != ST_IDLE),
        .i_prescale_divisor(i_prescale_divisor),
        .i_clock_rate_factor(i_clock_rate_factor),
        .o_half_tick(half_tick)
    );

    assign cw_mode = i_frame_format_field == sync_serial_pkg::FMT_CONTROL_WORD;
    assign spi_ok = i_frame_format_field == sync_serial_pkg::FMT_SPI
        && i_clock_polarity_bit && i_clock_phase_bit;
    assign word_bits = {1'b0, i_data_size_field} + 5'h01;
    assign ext_rise = ext_clk && !state.prev_sclk;

    // ==========================================================
    // sequencer
    always_comb begin
        next_state = state;
        next_state.pop = 1'b0;
        next_state.push = 1'b0;
        next_state.prev_sclk = ext_clk;
        next_state.prev_fss = ext_fss;
        // clock pad driven only by a master
        next_state.sclk_oe = !i_slave_mode && i_port_enable_bit;
        unique case (state.phase)
            ST_IDLE: begin
                // idle levels; control word idles clock low
                next_state.sclk = !cw_mode;
                next_state.fss = 1'b1;
                next_state.sout = 1'b0;
                next_state.sout_oe = 1'b0;
                next_state.in_response = 1'b0;
                if (i_port_enable_bit && !i_slave_mode && i_tx_valid
                        && (spi_ok || cw_mode)) begin
                    // fifo bottom loads at select fall
                    next_state.phase = ST_SETUP;
                    next_state.fss = 1'b0;
                    next_state.sout_oe = 1'b1;
                    next_state.pop = 1'b1;
                    next_state.shift_out = i_tx_data;
                    next_state.shift_in = 16'h0000;
                    next_state.bits_left = cw_mode
                        ? sync_serial_pkg::CONTROL_BITS : word_bits;
                    next_state.wait_bit = 1'b0;
                end else if (i_port_enable_bit && i_slave_mode && cw_mode
                        && !ext_fss && state.prev_fss) begin
                    // slave: frame from external select fall
                    next_state.phase = ST_FIRST;
                    next_state.sclk_oe = 1'b0;
                    next_state.bits_left = sync_serial_pkg::CONTROL_BITS;
                    next_state.in_response = 1'b0;
                end
            end
            ST_SETUP: begin
                // first data half period after select fall
                if (half_tick) begin
                    next_state.phase = ST_FIRST;
                    next_state.sclk = 1'b0;
                    next_state.sout = cw_mode
                        ? state.shift_out[7] : state.shift_out[i_data_size_field];
                end
            end
            ST_FIRST: begin
                if (i_slave_mode) begin
                    // slave latches on rising external clock
                    if (ext_fss) begin
                        next_state.phase = ST_IDLE;
                    end else if (ext_rise) begin
                        next_state.shift_in = {state.shift_in[14:0], ext_in};
                        next_state.bits_left = state.bits_left - 5'h01;
                        if (state.bits_left == 5'h01) begin
                            next_state.rx_data = 16'(
                                {state.shift_in[6:0], ext_in});
                            next_state.push = 1'b1;
                            next_state.bits_left = sync_serial_pkg::CONTROL_BITS;
                        end
                    end
                end else if (half_tick) begin
                    next_state.sclk = 1'b1;
                    next_state.phase = ST_SECOND;
                    if (state.wait_bit) begin
                        next_state.wait_bit = 1'b0;
                    end else begin
                        if (!cw_mode || state.in_response) begin
                            next_state.shift_in =
                                {state.shift_in[14:0], ext_in};
                        end
                        next_state.bits_left = state.bits_left - 5'h01;
                    end
                end
            end
            ST_SECOND: begin
                if (half_tick) begin
                    if (state.bits_left != 5'h00 || state.wait_bit) begin
                        next_state.phase = ST_FIRST;
                        next_state.sclk = 1'b0;
                        next_state.shift_out = {state.shift_out[14:0], 1'b0};
                        next_state.sout = cw_mode
                            ? state.shift_out[6]
                            : state.shift_out[i_data_size_field - 4'h1];
                        if (state.wait_bit) begin
                            next_state.sout = 1'b0;
                        end
                    end else if (cw_mode && !state.in_response) begin
                        // one idle clock, then response bits
                        next_state.phase = ST_FIRST;
                        next_state.sclk = 1'b0;
                        next_state.sout = 1'b0;
                        next_state.in_response = 1'b1;
                        next_state.wait_bit = 1'b1;
                        next_state.bits_left = word_bits;
                    end else if (i_tx_valid && i_port_enable_bit) begin
                        next_state.rx_data = state.shift_in;
                        next_state.push = 1'b1;
                        next_state.pop = 1'b1;
                        next_state.shift_out = i_tx_data;
                        next_state.shift_in = 16'h0000;
                        next_state.phase = ST_FIRST;
                        next_state.in_response = 1'b0;
                        next_state.sclk = 1'b0;
                        next_state.sout = cw_mode
                            ? i_tx_data[7] : i_tx_data[i_data_size_field];
                        next_state.bits_left = cw_mode
                            ? sync_serial_pkg::CONTROL_BITS : word_bits;
                    end else begin
                        next_state.phase = ST_TAIL;
                        next_state.tail_half = 1'b1;
                    end
                end
            end
            ST_TAIL: begin
                // select rises one period after last capture
                if (half_tick) begin
                    next_state.phase = ST_IDLE;
                    next_state.tail_half = 1'b0;
                    // word handed over at frame end
                    next_state.rx_data = state.shift_in;
                    next_state.push = 1'b1;
                    next_state.fss = 1'b1;
                    next_state.sout = 1'b0;
                    next_state.sout_oe = 1'b0;
                    next_state.sclk = !cw_mode;
                end
            end
            default: begin
                next_state.phase = ST_IDLE;
            end
        endcase
        if (!i_port_enable_bit) begin
            next_state.phase = ST_IDLE;
            next_state.fss = 1'b1;
            next_state.sout_oe = 1'b0;
        end
        if (i_slave_mode && i_slave_out_disable) begin
            next_state.sout_oe = 1'b0;
        end
        next_state.busy = next_state.phase != ST_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '{phase: ST_IDLE, sclk: 1'b1, fss: 1'b1,
                prev_sclk: 1'b1, prev_fss: 1'b1, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign o_serial_clock_pin = state.sclk;
    assign o_serial_clock_pin_oe = state.sclk_oe;
    assign o_frame_select_pin = state.fss;
    assign o_frame_select_pin_oe = state.sclk_oe;
    assign o_serial_out_pin = state.sout;
    assign o_serial_out_pin_oe = state.sout_oe;
    assign o_tx_pop = state.pop;
    assign o_rx_push = state.push;
    assign o_rx_data = state.rx_data;
    assign o_busy = state.busy;

    // ==========================================================
    // checks
    a_idle_spi_levels: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_IDLE && !cw_mode && $past(state.phase == ST_IDLE)
        |-> o_frame_select_pin && !o_serial_out_pin)
        else $error("spi idle levels wrong");
    a_pad_master_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_slave_mode |=> !o_serial_clock_pin_oe)
        else $error("clock pad driven in slave");
    a_start_select_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_IDLE && next_state.phase == ST_SETUP
        |=> !o_frame_select_pin && o_tx_pop)
        else $error("start without select low");
    a_select_low_frame: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase inside {ST_FIRST, ST_SECOND} && !i_slave_mode
        |-> !o_frame_select_pin)
        else $error("select high mid frame");
    a_clock_first_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_SETUP && half_tick |=> !o_serial_clock_pin)
        else $error("first clock edge not falling");
    a_rise_in_second: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_SECOND |-> o_serial_clock_pin)
        else $error("clock low in sample half");
    a_push_at_end: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_TAIL && state.tail_half && half_tick
        |=> o_rx_push && o_frame_select_pin)
        else $error("frame end without push");
    a_cw_idle_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_IDLE && cw_mode && $past(state.phase == ST_IDLE)
        && $past(cw_mode) |-> !o_serial_clock_pin)
        else $error("control word idle clock high");
    c_spi_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        !cw_mode && o_rx_push);
    c_cw_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        cw_mode && state.in_response && o_rx_push);
    c_back_to_back: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        state.phase == ST_FIRST && o_tx_pop && o_rx_push);
endmodule
`default_nettype wire

// ==== verification/serial_slave_model.sv ====
// off-chip serial partner for spi 1/1 and control-word frames
`timescale 1ns/100ps
`default_nettype none
module serial_slave_model (
    // serial pins
    input wire logic i_sclk,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    output logic o_miso,
    // response setup and captured bits
    input wire logic i_cw_mode,
    input wire logic [15:0] i_resp,
    input wire logic [4:0] i_resp_bits,
    output logic [15:0] o_got
);
    // ==========================================
    // slave behaviour
    int rises = 0;
    int sent = 0;
    logic drive = 1'b0;
    logic last = 1'b0;
    // released line shows the inverse of its last value
    assign o_miso = drive ? last : ~last;
    always @(negedge i_ss_n) begin
        rises = 0;
        sent = 0;
        o_got = 16'h0000;
    end
    always @(posedge i_ss_n) drive = 1'b0;
    // capture on rising, control bits only in control-word mode
    always @(posedge i_sclk) begin
        if (!i_ss_n) begin
            rises++;
            if (!i_cw_mode || rises <= 8) o_got = {o_got[14:0], i_mosi};
            // next control byte follows the lsb
            if (i_cw_mode && rises == 9 + i_resp_bits) begin
                rises = 0;
                sent = 0;
            end
        end
    end
    // drive on falling after the wait bit
    always @(negedge i_sclk) begin
        drive = 1'b0;
        if (!i_ss_n && (!i_cw_mode || rises >= 9)
                && sent < i_resp_bits) begin
            drive = 1'b1;
            last = i_resp[i_resp_bits - 1 - sent];
            sent++;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_sync_serial_frame_engine.sv ====
// self-checking bench for the serial frame engine
`timescale 1ns/100ps
`default_nettype none
module tb_sync_serial_frame_engine;
    // ==========================================
    // stimulus, wires and monitors
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, slv = 1'b0, cpol = 1'b1;
    logic tx_valid = 1'b0, cw = 1'b0, ext_din = 1'b0;
    logic ext_clk = 1'b0, ext_ss_n = 1'b1;
    logic [1:0] fmt = sync_serial_pkg::FMT_SPI;
    logic [3:0] data_size_field = 4'h7;
    logic [15:0] tx_data = 16'h0000, resp = 16'h0000;
    logic [4:0] resp_bits = 5'h08;
    logic [15:0] rx_data, got;
    logic tx_pop, rx_push, busy, sck, sck_oe, ss, ss_oe, so, so_oe;
    wire miso;
    wire sclk_w = sck_oe ? sck : ext_clk;
    wire ss_w = ss_oe ? ss : ext_ss_n;
    wire din_w = slv ? ext_din : miso;
    int failures = 0, samples_checked = 0, n_rise = 0, n_fall = 0, n_ssr = 0;
    realtime t_rise, t_fall1, t_ssf, t_ssr;
    logic [15:0] rxq[$];

    sync_serial_frame_engine uut (
        .i_clk(clk),
        .i_rst_n(rst_n),
        .i_port_enable_bit(en),
        .i_slave_mode(slv),
        .i_slave_out_disable(1'b0),
        .i_frame_format_field(fmt),
        .i_data_size_field(data_size_field),
        .i_clock_polarity_bit(cpol),
        .i_clock_phase_bit(1'b1),
        .i_prescale_divisor(8'h02),
        .i_clock_rate_factor(8'h04),
        .i_tx_valid(tx_valid),
        .i_tx_data(tx_data),
        .o_tx_pop(tx_pop),
        .o_rx_push(rx_push),
        .o_rx_data(rx_data),
        .o_busy(busy),
        .i_serial_clock_pin(sclk_w),
        .o_serial_clock_pin(sck),
        .o_serial_clock_pin_oe(sck_oe),
        .i_frame_select_pin(ss_w),
        .o_frame_select_pin(ss),
        .o_frame_select_pin_oe(ss_oe),
        .o_serial_out_pin(so),
        .o_serial_out_pin_oe(so_oe),
        .i_serial_in_pin(din_w)
    );

    serial_slave_model model (
        .i_sclk(sclk_w),
        .i_ss_n(ss_w),
        .i_mosi(so),
        .o_miso(miso),
        .i_cw_mode(cw),
        .i_resp(resp),
        .i_resp_bits(resp_bits),
        .o_got(got)
    );

    always @(posedge sclk_w) begin
        t_rise = $realtime;
        n_rise++;
    end
    always @(negedge sclk_w) begin
        if (n_fall == 0) t_fall1 = $realtime;
        n_fall++;
    end
    always @(negedge ss_w) begin
        t_ssf = $realtime;
        n_fall = 0;
        n_rise = 0;
    end
    always @(posedge ss_w) begin
        t_ssr = $realtime;
        n_ssr++;
    end
    always @(negedge clk) if (rx_push === 1'b1) rxq.push_back(rx_data);

    // peripheral clock runs before the port is used
    initial forever #4 clk = ~clk;

    // ==========================================
    // shared tasks
    task automatic chk_val(input string what, input logic [15:0] exp,
                           input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_ns(input string what, input int exp, input int seen);
        samples_checked++;
        if (seen != exp) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic cfg(input logic [1:0] f, input logic [3:0] d,
                       input logic s, input logic p);
        @(negedge clk);
        en = 1'b0;
        @(negedge clk);
        slv = s;
        fmt = f;
        data_size_field = d;
        cpol = p;
        @(negedge clk);
        en = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic run_frames(input logic [15:0] w0, input logic [15:0] w1,
                              input int n);
        int k;
        rxq.delete();
        n_ssr = 0;
        tx_data = w0;
        tx_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            k = 0;
            @(negedge clk);
            while (tx_pop !== 1'b1 && k < 400) begin
                @(negedge clk);
                k++;
            end
            chk_val("pop seen", 16'h0001, {15'h0, tx_pop});
            chk_val("select low at pop", 16'h0000, {15'h0, ss});
            chk_val("out pad on at pop", 16'h0001, {15'h0, so_oe});
            chk_val("busy at pop", 16'h0001, {15'h0, busy});
            tx_data = w1;
            if (i == n - 1) tx_valid = 1'b0;
        end
        k = 0;
        while (rxq.size() < n && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk_val("push count", 16'(n), 16'(rxq.size()));
        repeat (2) @(negedge clk);
    endtask

    // ==========================================
    // scenarios
    task automatic test_spi_single();
        cfg(sync_serial_pkg::FMT_SPI, 4'h7, 1'b0, 1'b1);
        chk_val("spi idle pins", 16'h000e, {12'h0, sck_oe, sck, ss, so});
        cw = 1'b0;
        resp = 16'h003c;
        resp_bits = 5'h08;
        run_frames(16'h00a5, 16'h0000, 1);
        chk_val("spi rx word", 16'h003c, rxq[0]);
        chk_val("spi tx word", 16'h00a5, got);
        chk_ns("spi rises", 8, n_rise);
        chk_ns("first fall delay", 40, int'(t_fall1 - t_ssf));
        chk_ns("select rise delay", 80, int'(t_ssr - t_rise));
        chk_val("spi clock idle", 16'h0001, {15'h0, sck});
        $display("spi single word done");
    endtask

    task automatic test_spi_b2b();
        resp = 16'h5a96;
        resp_bits = 5'h10;
        run_frames(16'h0081, 16'h007e, 2);
        chk_ns("b2b select rises", 1, n_ssr);
        chk_ns("b2b rises", 16, n_rise);
        chk_val("b2b tx words", 16'h817e, got);
        chk_val("b2b rx first", 16'h005a, rxq[0]);
        chk_val("b2b rx second", 16'h0096, rxq[1]);
        $display("spi back-to-back done");
    endtask

    task automatic test_cw();
        cfg(sync_serial_pkg::FMT_CONTROL_WORD, 4'hb, 1'b0, 1'b1);
        chk_val("cw idle pins", 16'h0002, {13'h0, sck, ss, so});
        cw = 1'b1;
        resp = 16'h0b4e;
        resp_bits = 5'h0c;
        run_frames(16'h00c5, 16'h0000, 1);
        chk_val("cw control", 16'h00c5, got);
        chk_val("cw rx word", 16'h0b4e, rxq[0]);
        chk_ns("cw rises", 21, n_rise);
        chk_ns("cw select rise", 80, int'(t_ssr - t_rise));
        run_frames(16'h0033, 16'h00cc, 2);
        chk_ns("cont select rises", 1, n_ssr);
        chk_ns("cont rises", 42, n_rise);
        chk_val("cont controls", 16'h33cc, got);
        chk_val("cont rx second", 16'h0b4e, rxq[1]);
        $display("control word frames done");
    endtask

    task automatic test_refused();
        int pops;
        logic [1:0] fs[3] = '{2'h1, 2'h3, 2'h0};
        for (int i = 0; i < 3; i++) begin
            cfg(fs[i], 4'h7, 1'b0, i != 2);
            pops = 0;
            tx_valid = 1'b1;
            repeat (60) begin
                @(negedge clk);
                pops += int'(tx_pop === 1'b1);
            end
            tx_valid = 1'b0;
            chk_ns("refused pops", 0, pops);
        end
        $display("refused formats done");
    endtask

    task automatic test_slave();
        int k;
        logic [7:0] b = 8'hd3;
        cfg(sync_serial_pkg::FMT_CONTROL_WORD, 4'h7, 1'b1, 1'b1);
        chk_val("slave clock oe", 16'h0000, {15'h0, sck_oe});
        rxq.delete();
        ext_ss_n = 1'b0;
        // select set up two periods ahead
        #160;
        for (int i = 7; i >= 0; i--) begin
            ext_din = b[i];
            #40 ext_clk = 1'b1;
            #40 ext_clk = 1'b0;
            ext_din = ~b[i];
        end
        #80 ext_ss_n = 1'b1;
        k = 0;
        while (rxq.size() < 1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        chk_val("slave word", 16'h00d3, rxq[0]);
        $display("slave receive done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        test_spi_single();
        test_spi_b2b();
        test_cw();
        test_refused();
        test_slave();
        print_verdict();
    end
endmodule
`default_nettype wire
